// ### core/rco_pkg.sv
/*
 * Shared constants for the reference clock output block: register
 * indices, field positions, reset values, source codes and the
 * generator state encoding.
 * Assumes a 16-bit register port with a 3-bit word index.
 */
`default_nettype none

package rco_pkg;

	// register port
	localparam int ADDR_W = 3;
	localparam int DATA_W = 16;

	// register indices
	localparam logic [2:0] OFS_TUNE = 3'h0;
	localparam logic [2:0] OFS_PLL_OUTPUT_DIVIDER = 3'h1;
	localparam logic [2:0] OFS_CTRL_LO = 3'h2;
	localparam logic [2:0] OFS_CTRL_HI = 3'h3;
	localparam logic [2:0] OFS_TRIM = 3'h4;

	// field positions and widths
	localparam int TUNE_LSB = 0;
	localparam int TUNE_W = 6;
	localparam int VCO_SEL_LSB = 8;
	localparam int POST_A_LSB = 4;
	localparam int POST_B_LSB = 0;
	localparam int POST_W = 3;
	localparam int GEN_ON_BIT = 15;
	localparam int IDLE_STOP_BIT = 13;
	localparam int PIN_DRIVE_BIT = 12;
	localparam int SLEEP_RUN_BIT = 11;
	localparam int SWITCH_REQ_BIT = 9;
	localparam int RUNNING_BIT = 8;
	localparam int SEL_LSB = 0;
	localparam int SEL_W = 4;
	localparam int DIV_LSB = 0;
	localparam int DIV_W = 15;
	localparam int TRIM_LSB = 7;
	localparam int TRIM_W = 9;

	// reset values
	localparam logic [5:0] TUNE_RST = 6'h00;
	localparam logic [1:0] VCO_SEL_RST = 2'h0;
	localparam logic [2:0] POST_A_RST = 3'h4;
	localparam logic [2:0] POST_B_RST = 3'h1;
	localparam logic [3:0] SEL_RST = 4'h0;
	localparam logic [14:0] DIV_RST = 15'h0000;
	localparam logic [8:0] TRIM_RST = 9'h000;

	// reference source codes; codes 8 to 15 are reserved
	localparam logic [3:0] SRC_SYS = 4'h0;
	localparam logic [3:0] SRC_PERIPH = 4'h1;
	localparam logic [3:0] SRC_PRIMARY = 4'h2;
	localparam logic [3:0] SRC_FAST_RC = 4'h3;
	localparam logic [3:0] SRC_LOW_POWER_RC = 4'h4;
	localparam logic [3:0] SRC_BACKUP_RC = 4'h5;
	localparam logic [3:0] SRC_VCO4 = 4'h6;
	localparam logic [3:0] SRC_PIN = 4'h7;
	localparam int SRC_COUNT = 8;

	typedef enum logic [1:0] {
		GEN_OFF = 2'b00,
		GEN_RUN = 2'b01,
		GEN_DRAIN = 2'b11
	} rco_gen_t;

endpackage

`default_nettype wire

// ### core/rco_half_div.sv
/*
 * Half-period counter with fractional trim accumulator for the
 * reference clock generator.
 * Assumes i_tick is a one-cycle enable per source rising edge and
 * that i_div is nonzero whenever i_run is high.
 */
`default_nettype none

module rco_half_div
	import rco_pkg::*;
(
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_b,
	// control
	input wire logic i_run,
	input wire logic i_tick,
	input wire logic [DIV_W-1:0] i_div,
	input wire logic [TRIM_W-1:0] i_trim,
	// result
	output logic o_half_end
);

	logic [DIV_W:0] cnt;
	logic [TRIM_W-1:0] acc;
	logic carry;
	logic [DIV_W:0] next_cnt;
	logic [TRIM_W-1:0] next_acc;
	logic next_carry;
	logic [DIV_W:0] len;
	logic [TRIM_W:0] sum;

	always_comb begin
		len = {1'b0, i_div} + {{DIV_W{1'b0}}, carry};
		sum = {1'b0, acc} + {1'b0, i_trim};
		o_half_end = i_run && i_tick && (cnt == len - 1'b1);
		next_cnt = cnt;
		next_acc = acc;
		next_carry = carry;
		if (!i_run) begin
			next_cnt = '0;
			next_acc = '0;
			next_carry = 1'b0;
		end else if (o_half_end) begin
			// overflow stretches the next half by one source cycle
			next_cnt = '0;
			next_acc = sum[TRIM_W-1:0];
			next_carry = sum[TRIM_W];
		end else if (i_tick) begin
			next_cnt = cnt + 1'b1;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt <= '0;
			acc <= '0;
			carry <= 1'b0;
		end else begin
			cnt <= next_cnt;
			acc <= next_acc;
			carry <= next_carry;
		end
	end

	a_frac_stretch: assert property (@(posedge i_clock) disable iff (!i_rst_b)
		o_half_end && sum[TRIM_W] |=> len == {1'b0, i_div} + 1'b1)
		else $error("fraction overflow did not stretch the next half");

	a_half_length: assert property (@(posedge i_clock) disable iff (!i_rst_b)
		o_half_end |-> cnt == {1'b0, i_div} + carry - 1'b1)
		else $error("half period length differs from divider plus carry");

endmodule

`default_nettype wire

// ### core/rco_refclk_ctrl.sv
/*
 * Clock generation control: RC tuning trim, PLL output divider
 * settings, VCO output divider and the reference clock generator.
 * Assumes source clocks arrive asynchronously on i_src_clk (bit 6
 * carries the raw VCO) and are far slower than i_clock; idle and
 * sleep indications come from logic on i_clock.
 */
// The address map and strobed register access are this design's own decisions.
`default_nettype none

// Operation
// - the RC tuning field is a signed six-bit step around the 8 MHz centre.
// - the VCO output is divided by 1, 2, 3 or 4 for selects 11, 10, 01, 00.
// - the reference generator runs only while its enable bit is set; after a clear it runs on until its output is low.
// - with idle-stop set the generator halts in Idle, else it keeps running.
// - the reference clock reaches the pin only while pin drive is set.
// - with sleep-run set the generator runs in Sleep, else it stops there.
// - software sets the switch request, hardware clears it on completion.
// - a read-only flag shows the generator running; change nothing until low.
// - a 4-bit code picks the source; codes 8 to 15 are reserved.
// - the source is divided by twice the 15-bit divider, zero passes it through.
// - a 9-bit fraction in 512ths is added to each half period.

module rco_refclk_ctrl
	import rco_pkg::*;
(
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_b,
	// register port
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [DATA_W-1:0] o_rdata,
	// power modes
	input wire logic i_idle,
	input wire logic i_sleep,
	// asynchronous source clocks
	input wire logic [SRC_COUNT-1:0] i_src_clk,
	// trim and divider settings
	output logic [TUNE_W-1:0] o_rc_trim_step,
	output logic [POST_W-1:0] o_pll_post_div_a,
	output logic [POST_W-1:0] o_pll_post_div_b,
	output logic o_vco_out_tick,
	// reference clock pin
	output logic o_refclk_out_pin,
	output logic o_refclk_out_oe,
	output logic o_refclk_running_flag
);

	// register state
	logic [TUNE_W-1:0] rc_trim_step, next_rc_trim_step;
	logic [1:0] vco_out_div_sel, next_vco_out_div_sel;
	logic [POST_W-1:0] pll_post_div_a, next_pll_post_div_a;
	logic [POST_W-1:0] pll_post_div_b, next_pll_post_div_b;
	logic refclk_gen_on, next_refclk_gen_on;
	logic refclk_idle_stop, next_refclk_idle_stop;
	logic refclk_pin_drive, next_refclk_pin_drive;
	logic refclk_sleep_run, next_refclk_sleep_run;
	logic refclk_div_switch_req, next_refclk_div_switch_req;
	logic [SEL_W-1:0] refclk_source_sel, next_refclk_source_sel;
	logic [DIV_W-1:0] refclk_int_divider, next_refclk_int_divider;
	logic [TRIM_W-1:0] refclk_frac_trim, next_refclk_frac_trim;
	logic [DATA_W-1:0] rdata, next_rdata;
	logic [DATA_W-1:0] rd_word;
	logic sw_sets_req;

	// synchronisers and source edges
	logic [SRC_COUNT-1:0] src_s1, src_s2, src_s3;
	logic [SRC_COUNT-1:0] src_rise;
	logic [1:0] vco_cnt, next_vco_cnt;
	logic [1:0] vco4_cnt, next_vco4_cnt;
	logic vco_tick, next_vco_tick;
	logic sel_tick, sel_lvl;

	// generator state
	rco_gen_t state, next_state;
	logic out, next_out;
	logic pin, next_pin;
	logic oe, next_oe;
	logic running, next_running;
	logic [DIV_W-1:0] act_div, next_act_div;
	logic [TRIM_W-1:0] act_trim, next_act_trim;
	logic run_ok, bypass, half_end, half_done, switch_done;

	// register file
	always_comb begin
		next_rc_trim_step = rc_trim_step;
		next_vco_out_div_sel = vco_out_div_sel;
		next_pll_post_div_a = pll_post_div_a;
		next_pll_post_div_b = pll_post_div_b;
		next_refclk_gen_on = refclk_gen_on;
		next_refclk_idle_stop = refclk_idle_stop;
		next_refclk_pin_drive = refclk_pin_drive;
		next_refclk_sleep_run = refclk_sleep_run;
		next_refclk_div_switch_req = refclk_div_switch_req;
		next_refclk_source_sel = refclk_source_sel;
		next_refclk_int_divider = refclk_int_divider;
		next_refclk_frac_trim = refclk_frac_trim;
		sw_sets_req = i_wr && (i_addr == OFS_CTRL_LO) &&
			i_wdata[SWITCH_REQ_BIT];
		if (i_wr) begin
			case (i_addr)
				OFS_TUNE: begin
					next_rc_trim_step = i_wdata[TUNE_LSB +: TUNE_W];
				end
				OFS_PLL_OUTPUT_DIVIDER: begin
					next_vco_out_div_sel = i_wdata[VCO_SEL_LSB +: 2];
					next_pll_post_div_a = i_wdata[POST_A_LSB +: POST_W];
					next_pll_post_div_b = i_wdata[POST_B_LSB +: POST_W];
				end
				OFS_CTRL_LO: begin
					next_refclk_gen_on = i_wdata[GEN_ON_BIT];
					next_refclk_idle_stop = i_wdata[IDLE_STOP_BIT];
					next_refclk_pin_drive = i_wdata[PIN_DRIVE_BIT];
					next_refclk_sleep_run = i_wdata[SLEEP_RUN_BIT];
					next_refclk_source_sel = i_wdata[SEL_LSB +: SEL_W];
				end
				OFS_CTRL_HI: begin
					next_refclk_int_divider = i_wdata[DIV_LSB +: DIV_W];
				end
				OFS_TRIM: begin
					next_refclk_frac_trim = i_wdata[TRIM_LSB +: TRIM_W];
				end
				default: begin
				end
			endcase
		end
		// writing zero cannot cancel a pending switch; a new set beats
		// the completion clear in the same cycle
		if (sw_sets_req) begin
			next_refclk_div_switch_req = 1'b1;
		end else if (switch_done) begin
			next_refclk_div_switch_req = 1'b0;
		end
		rd_word = '0;
		case (i_addr)
			OFS_TUNE: rd_word[TUNE_LSB +: TUNE_W] = rc_trim_step;
			OFS_PLL_OUTPUT_DIVIDER: begin
				rd_word[VCO_SEL_LSB +: 2] = vco_out_div_sel;
				rd_word[POST_A_LSB +: POST_W] = pll_post_div_a;
				rd_word[POST_B_LSB +: POST_W] = pll_post_div_b;
			end
			OFS_CTRL_LO: begin
				rd_word[GEN_ON_BIT] = refclk_gen_on;
				rd_word[IDLE_STOP_BIT] = refclk_idle_stop;
				rd_word[PIN_DRIVE_BIT] = refclk_pin_drive;
				rd_word[SLEEP_RUN_BIT] = refclk_sleep_run;
				rd_word[SWITCH_REQ_BIT] = refclk_div_switch_req;
				rd_word[RUNNING_BIT] = running;
				rd_word[SEL_LSB +: SEL_W] = refclk_source_sel;
			end
			OFS_CTRL_HI: rd_word[DIV_LSB +: DIV_W] = refclk_int_divider;
			OFS_TRIM: rd_word[TRIM_LSB +: TRIM_W] = refclk_frac_trim;
			default: rd_word = '0;
		endcase
		next_rdata = i_rd ? rd_word : '0;
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rc_trim_step <= TUNE_RST;
			vco_out_div_sel <= VCO_SEL_RST;
			pll_post_div_a <= POST_A_RST;
			pll_post_div_b <= POST_B_RST;
			refclk_gen_on <= 1'b0;
			refclk_idle_stop <= 1'b0;
			refclk_pin_drive <= 1'b0;
			refclk_sleep_run <= 1'b0;
			refclk_div_switch_req <= 1'b0;
			refclk_source_sel <= SEL_RST;
			refclk_int_divider <= DIV_RST;
			refclk_frac_trim <= TRIM_RST;
			rdata <= '0;
		end else begin
			rc_trim_step <= next_rc_trim_step;
			vco_out_div_sel <= next_vco_out_div_sel;
			pll_post_div_a <= next_pll_post_div_a;
			pll_post_div_b <= next_pll_post_div_b;
			refclk_gen_on <= next_refclk_gen_on;
			refclk_idle_stop <= next_refclk_idle_stop;
			refclk_pin_drive <= next_refclk_pin_drive;
			refclk_sleep_run <= next_refclk_sleep_run;
			refclk_div_switch_req <= next_refclk_div_switch_req;
			refclk_source_sel <= next_refclk_source_sel;
			refclk_int_divider <= next_refclk_int_divider;
			refclk_frac_trim <= next_refclk_frac_trim;
			rdata <= next_rdata;
		end
	end

	// two flops per source, a third only for edge detection
	for (genvar g = 0; g < SRC_COUNT; g++) begin : g_sync
		always_ff @(posedge i_clock or negedge i_rst_b) begin
			if (!i_rst_b) begin
				src_s1[g] <= 1'b0;
				src_s2[g] <= 1'b0;
				src_s3[g] <= 1'b0;
			end else begin
				src_s1[g] <= i_src_clk[g];
				src_s2[g] <= src_s1[g];
				src_s3[g] <= src_s2[g];
			end
		end
	end
	assign src_rise = src_s2 & ~src_s3;

	// VCO output divider and the fixed divide-by-four source
	always_comb begin
		next_vco_cnt = vco_cnt;
		next_vco4_cnt = vco4_cnt;
		next_vco_tick = 1'b0;
		if (src_rise[SRC_VCO4[2:0]]) begin
			next_vco4_cnt = vco4_cnt + 2'h1;
			// ratio minus one equals the inverted select
			if (vco_cnt == ~vco_out_div_sel) begin
				next_vco_cnt = 2'h0;
				next_vco_tick = 1'b1;
			end else begin
				next_vco_cnt = vco_cnt + 2'h1;
			end
		end
		// reserved codes select no clock, so the generator never steps
		if (refclk_source_sel[3]) begin
			sel_tick = 1'b0;
			sel_lvl = 1'b0;
		end else if (refclk_source_sel == SRC_VCO4) begin
			sel_tick = src_rise[SRC_VCO4[2:0]] && (vco4_cnt == 2'h1);
			sel_lvl = vco4_cnt[1];
		end else begin
			sel_tick = src_rise[refclk_source_sel[2:0]];
			sel_lvl = src_s2[refclk_source_sel[2:0]];
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			vco_cnt <= 2'h0;
			vco4_cnt <= 2'h0;
			vco_tick <= 1'b0;
		end else begin
			vco_cnt <= next_vco_cnt;
			vco4_cnt <= next_vco4_cnt;
			vco_tick <= next_vco_tick;
		end
	end

	rco_half_div u_half_div (
		.i_clock(i_clock),
		.i_rst_b(i_rst_b),
		.i_run(state != GEN_OFF && !bypass),
		.i_tick(sel_tick),
		.i_div(act_div),
		.i_trim(act_trim),
		.o_half_end(half_end)
	);

	// reference generator
	always_comb begin
		run_ok = refclk_gen_on &&
			!(i_idle && refclk_idle_stop) &&
			!(i_sleep && !refclk_sleep_run);
		bypass = (act_div == '0);
		half_done = bypass ? (sel_lvl != out) : half_end;
		switch_done = refclk_div_switch_req &&
			(state == GEN_OFF || half_done);
		next_state = state;
		next_out = out;
		next_act_div = act_div;
		next_act_trim = act_trim;
		if (switch_done) begin
			next_act_div = refclk_int_divider;
			next_act_trim = refclk_frac_trim;
		end
		case (state)
			GEN_OFF: begin
				next_out = 1'b0;
				if (run_ok) begin
					next_state = GEN_RUN;
				end
			end
			GEN_RUN: begin
				if (half_done) begin
					next_out = bypass ? sel_lvl : !out;
				end
				// stopping waits for a low phase so no runt pulse leaves
				if (!run_ok) begin
					next_state = (next_out ? GEN_DRAIN : GEN_OFF);
				end
			end
			GEN_DRAIN: begin
				if (half_done) begin
					next_out = 1'b0;
				end
				if (run_ok) begin
					next_state = GEN_RUN;
				end else if (!next_out) begin
					next_state = GEN_OFF;
				end
			end
			default: begin
				next_state = GEN_OFF;
				next_out = 1'b0;
			end
		endcase
		next_running = (next_state != GEN_OFF);
		next_pin = refclk_pin_drive && next_out;
		next_oe = refclk_pin_drive;
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state <= GEN_OFF;
			out <= 1'b0;
			pin <= 1'b0;
			oe <= 1'b0;
			running <= 1'b0;
			act_div <= DIV_RST;
			act_trim <= TRIM_RST;
		end else begin
			state <= next_state;
			out <= next_out;
			pin <= next_pin;
			oe <= next_oe;
			running <= next_running;
			act_div <= next_act_div;
			act_trim <= next_act_trim;
		end
	end

	assign o_rdata = rdata;
	assign o_rc_trim_step = rc_trim_step;
	assign o_pll_post_div_a = pll_post_div_a;
	assign o_pll_post_div_b = pll_post_div_b;
	assign o_vco_out_tick = vco_tick;
	assign o_refclk_out_pin = pin;
	assign o_refclk_out_oe = oe;
	assign o_refclk_running_flag = running;

	sequence s_tune_write;
		i_wr && i_addr == OFS_TUNE;
	endsequence

	a_tune_signed: assert property (@(posedge i_clock) disable iff (!i_rst_b)
		s_tune_write ##1 1'b1 |-> $signed(o_rc_trim_step) ==
		$signed($past(i_wdata[TUNE_LSB +: TUNE_W])))
		else $error("tuning step not taken from the write");

	a_vco_ratio: assert property (@(posedge i_clock) disable iff (!i_rst_b)
		src_rise[SRC_VCO4[2:0]] && vco_cnt == ~vco_out_div_sel
		|=> o_vco_out_tick && vco_cnt == 2'h0)
		else $error("VCO divider pulse missing at the selected ratio");

	a_gen_stays_off: assert property (@(posedge i_clock) disable iff (!i_rst_b)
		state == GEN_OFF && !refclk_gen_on |=> !o_refclk_running_flag)
		else $error("generator started while disabled");

	a_idle_halt: assert property (@(posedge i_clock) disable iff (!i_rst_b)
		state == GEN_OFF && i_idle && refclk_idle_stop
		|=> state == GEN_OFF)
		else $error("generator started in Idle with idle-stop set");

	a_pin_gate: assert property (@(posedge i_clock) disable iff (!i_rst_b)
		!refclk_pin_drive |=> !o_refclk_out_oe && !o_refclk_out_pin)
		else $error("pin driven while pin drive is clear");

	a_sleep_run: assert property (@(posedge i_clock) disable iff (!i_rst_b)
		state == GEN_OFF && refclk_gen_on && refclk_sleep_run &&
		i_sleep && !i_idle |=> state == GEN_RUN)
		else $error("generator did not start in Sleep with sleep-run set");

	a_switch_hold: assert property (@(posedge i_clock) disable iff (!i_rst_b)
		refclk_div_switch_req && !switch_done |=> refclk_div_switch_req)
		else $error("switch request dropped before completion");

	a_flag_cause: assert property (@(posedge i_clock) disable iff (!i_rst_b)
		$rose(o_refclk_running_flag) |-> $past(run_ok))
		else $error("running flag rose without the generator enabled");

	a_bypass_level: assert property (@(posedge i_clock) disable iff (!i_rst_b)
		state == GEN_RUN && bypass && run_ok
		|=> out == $past(sel_lvl))
		else $error("zero divider did not pass the source through");

	a_div_at_switch: assert property (@(posedge i_clock) disable iff (!i_rst_b)
		$changed(act_div) || $changed(act_trim) |-> $past(switch_done))
		else $error("active divider changed outside a switch");

endmodule

`default_nettype wire

// ### dv/rco_refclk_sink.sv
/*
 * Model of the circuit on the reference clock pin: it sees the pad
 * level, counts its rising edges and times the last full period in
 * clock cycles.
 * Assumes the pad carries a pull-down, so a released pin reads low.
 */
`default_nettype none

module rco_refclk_sink (
	// clock
	input wire logic i_clock,
	// pad
	input wire logic i_pin,
	input wire logic i_oe,
	// measurements
	output var int o_rises,
	output var int o_period
);
	timeunit 1ns;
	timeprecision 1ps;

	logic pad;
	logic pad_q = 1'b0;
	int since = 0;

	// the pin reaches the pad only while driven, else the pull-down wins
	assign pad = i_oe ? i_pin : 1'b0;

	initial begin
		o_rises = 0;
		o_period = 0;
	end

	always @(posedge i_clock) begin
		pad_q <= pad;
		since <= since + 1;
		if (pad && !pad_q) begin
			o_rises <= o_rises + 1;
			o_period <= since + 1;
			since <= 0;
		end
	end

endmodule

`default_nettype wire

// ### dv/rco_refclk_ctrl_tb.sv
/*
 * Self-checking bench for the reference clock output block: register
 * port, VCO output divider, source codes, division, trim and modes.
 * Assumes the pin sink model and the design package; every source
 * clock is made here with one rising edge each 16 clock cycles.
 */
`default_nettype none

module rco_refclk_ctrl_tb
	import rco_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic i_clock = 1'b0;
	logic i_rst_b = 1'b0;
	logic [ADDR_W-1:0] i_addr = '0;
	logic [DATA_W-1:0] i_wdata = '0;
	logic [DATA_W-1:0] o_rdata;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic i_idle = 1'b0;
	logic i_sleep = 1'b0;
	logic [SRC_COUNT-1:0] i_src_clk = '0;
	logic [TUNE_W-1:0] tstep;
	logic [POST_W-1:0] pa;
	logic [POST_W-1:0] pb;
	logic tick;
	logic pin;
	logic oe;
	logic flag;
	logic [3:0] cnt = 4'h0;
	int rises;
	int period;
	int bad_count = 0;
	int n_compared = 0;
	int cyc = 0;

	rco_refclk_ctrl dut (.i_clock(i_clock), .i_rst_b(i_rst_b),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_idle(i_idle), .i_sleep(i_sleep),
		.i_src_clk(i_src_clk), .o_rc_trim_step(tstep),
		.o_pll_post_div_a(pa), .o_pll_post_div_b(pb),
		.o_vco_out_tick(tick), .o_refclk_out_pin(pin),
		.o_refclk_out_oe(oe), .o_refclk_running_flag(flag));

	rco_refclk_sink sink (.i_clock(i_clock), .i_pin(pin), .i_oe(oe),
		.o_rises(rises), .o_period(period));

	initial forever #12.5 i_clock = ~i_clock;

	// sources are synchronous to the bench clock so periods are exact
	always @(posedge i_clock) begin
		cnt <= cnt + 4'h1;
		i_src_clk <= {SRC_COUNT{cnt[3]}};
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			bad_count++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h",
				$time, got, exp);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge i_clock);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clock);
		i_wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rdchk(input logic [2:0] a, input logic [15:0] e);
		@(posedge i_clock);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clock);
		i_rd <= 1'b0;
		#1 chk(o_rdata, e);
	endtask

	task automatic wait_flag(input logic v);
		int n;
		n = 0;
		while (flag !== v && n < 1000) begin
			@(posedge i_clock);
			#1 n++;
		end
		chk(16'(flag), 16'(v));
	endtask

	task automatic stop();
		wr(OFS_CTRL_LO, 16'h0000);
		wait_flag(1'b0);
	endtask

	// source and settings only change once the running flag is low
	task automatic cfg(input logic [3:0] s, input logic [14:0] dv,
		input logic [8:0] tr);
		stop();
		wr(OFS_CTRL_HI, {1'b0, dv});
		wr(OFS_TRIM, {tr, 7'h00});
		wr(OFS_CTRL_LO, {12'h920, s});
		wait_flag(1'b1);
		rdchk(OFS_CTRL_LO, {12'h910, s});
	endtask

	// skips the first rise, whose period spans the reconfiguration
	task automatic meas(output int p);
		int r0;
		int n;
		r0 = rises;
		n = 0;
		while (rises < r0 + 2 && n < 2000) begin
			@(posedge i_clock);
			#1 n++;
		end
		p = period;
	endtask

	task automatic t_regs();
		chk({5'h00, pa, 5'h00, pb}, 16'h0401);
		chk(16'({tstep, tick, pin, oe, flag}), 16'h0000);
		rdchk(OFS_TUNE, 16'h0000);
		rdchk(OFS_PLL_OUTPUT_DIVIDER, 16'h0041);
		rdchk(OFS_CTRL_LO, 16'h0000);
		rdchk(OFS_CTRL_HI, 16'h0000);
		rdchk(OFS_TRIM, 16'h0000);
		wr(OFS_TUNE, 16'hffe0);
		rdchk(OFS_TUNE, 16'h0020);
		chk(16'(tstep), 16'h0020);
		wr(OFS_TUNE, 16'h001f);
		#1 chk(16'(tstep), 16'h001f);
		wr(OFS_PLL_OUTPUT_DIVIDER, 16'hffff);
		rdchk(OFS_PLL_OUTPUT_DIVIDER, 16'h0377);
		chk(16'({pa, pb}), 16'h003f);
		wr(3'h5, 16'hffff);
		rdchk(3'h5, 16'h0000);
		wr(OFS_CTRL_LO, 16'h0100);
		rdchk(OFS_CTRL_LO, 16'h0000);
		wr(OFS_CTRL_HI, 16'hffff);
		rdchk(OFS_CTRL_HI, 16'h7fff);
		wr(OFS_TRIM, 16'hffff);
		rdchk(OFS_TRIM, 16'hff80);
		$display("test regs done");
	endtask

	// 48 raw edges in the window; one pulse of slack for alignment
	task automatic t_vco();
		int n;
		int e;
		for (int s = 0; s < 4; s++) begin
			// no PLL runs here, so the post ratios may be rewritten
			wr(OFS_PLL_OUTPUT_DIVIDER, {6'h00, 2'(s), 8'h41});
			repeat (64) @(posedge i_clock);
			n = 0;
			e = 48 / (4 - s);
			repeat (768) begin
				@(posedge i_clock);
				#1 if (tick === 1'b1) n++;
			end
			chk(16'(n >= e - 1 && n <= e + 1), 16'h0001);
		end
		$display("test vco done");
	endtask

	task automatic t_src();
		int p;
		int r0;
		for (int c = 0; c < 8; c++) begin
			cfg(4'(c), 15'h0002, 9'h000);
			meas(p);
			chk(16'(p), (c == 6) ? 16'h0100 : 16'h0040);
		end
		cfg(4'h0, 15'h0000, 9'h000);
		meas(p);
		chk(16'(p), 16'h0010);
		cfg(4'h0, 15'h0001, 9'h100);
		meas(p);
		chk(16'(p), 16'h0030);
		// divider and trim written alone wait for a switch request
		wr(OFS_TRIM, 16'h0000);
		wr(OFS_CTRL_HI, 16'h0002);
		meas(p);
		chk(16'(p), 16'h0030);
		// the request lands early in a high half, so it is still pending
		wr(OFS_CTRL_LO, 16'h9200);
		rdchk(OFS_CTRL_LO, 16'h9300);
		meas(p);
		chk(16'(p), 16'h0040);
		rdchk(OFS_CTRL_LO, 16'h9100);
		cfg(4'h8, 15'h0001, 9'h000);
		r0 = rises;
		repeat (300) @(posedge i_clock);
		chk(16'(rises - r0), 16'h0000);
		$display("test sources done");
	endtask

	// md: idle, sleep, expected flag, expected pin activity
	task automatic t_modes();
		logic [15:0] lo [5] = '{16'hb000, 16'h9000, 16'h9000, 16'h9800,
			16'h8000};
		logic [3:0] md [5] = '{4'b1000, 4'b1011, 4'b0100, 4'b0111,
			4'b0010};
		int r0;
		cfg(4'h0, 15'h0001, 9'h000);
		for (int k = 0; k < 5; k++) begin
			stop();
			@(posedge i_clock);
			i_idle <= md[k][3];
			i_sleep <= md[k][2];
			wr(OFS_CTRL_LO, lo[k]);
			r0 = rises;
			repeat (200) @(posedge i_clock);
			#1 chk(16'(flag), 16'(md[k][1]));
			chk(16'(rises > r0), 16'(md[k][0]));
			chk(16'(oe), 16'(lo[k][12]));
			@(posedge i_clock);
			i_idle <= 1'b0;
			i_sleep <= 1'b0;
		end
		stop();
		$display("test modes done");
	endtask

	initial begin
		repeat (5) @(posedge i_clock);
		i_rst_b <= 1'b1;
		repeat (2) @(posedge i_clock);
		t_regs();
		t_vco();
		t_src();
		t_modes();
		report_and_stop();
	end

endmodule

`default_nettype wire
